// *** hw/afs_consts.svh ***
// offsets, field positions, reset values and sizes of the frame sequencer
// assumes byte-wide register port with 16-bit addresses
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define AFS_OFF_SLOT_CNT   16'h2100
`define AFS_OFF_SEL_LAST   16'h2105
`define AFS_OFF_CHOP       16'h2106
`define AFS_OFF_FIR_DIFF   16'h210C
`define AFS_OFF_ADC_DIV    16'h2200
`define AFS_OFF_SEQ_CFG    16'h2110
`define AFS_OFF_STATUS     16'h2111
// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define AFS_CHOP_LSB       2
`define AFS_FIR_LSB        1
`define AFS_DIFF_LSB       4
`define AFS_DIV_BIT        5
`define AFS_CFG_FAST_BIT   0
`define AFS_CFG_RMT_BIT    1
`define AFS_MASK_CHOP      8'hEC
`define AFS_MASK_FIR_DIFF  8'h36
`define AFS_MASK_ADC_DIV   8'h20
`define AFS_MASK_SEQ_CFG   8'h03
`define AFS_RST_BYTE       8'h00
`define AFS_RST_NIB        4'h0
// ----------------------------------------
// sequence sizes
// ----------------------------------------
`define AFS_NUM_SLOTS      11
`define AFS_MAX_SLOT_CNT   4'hB
`define AFS_TAIL_SLOW      4'h3
`define AFS_TAIL_FAST      4'h1
`define AFS_SLOW_MULT      3'h3
`define AFS_RMT_ADDR_BASE  4'hB
`define AFS_SAMPLE_W       24
`define AFS_RMT_WORD_W     26
`define AFS_FIFO_DEPTH     8
`define AFS_CHOP_POS       2'h1
`define AFS_CHOP_NEG       2'h2
`define AFS_SHUNT_DIFF     4'h1
`define AFS_CT_DIFF        4'hF
`endif

// *** hw/afs_fifo.sv ***
// synchronous FIFO with valid/ready on both sides
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/10ps
module afs_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  // fill side
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [WIDTH-1:0]           i_in_data,
  // drain side
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [WIDTH-1:0]                o_out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]      o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0]          mem_r [0:DEPTH-1];
  logic [AW-1:0]             wr_ptr_r;
  logic [AW-1:0]             rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] count_r;
  logic                      push;
  logic                      pop;

  assign o_in_ready  = (count_r != CW'(DEPTH));
  assign o_out_valid = (count_r != '0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign o_count     = count_r;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule : afs_fifo

// *** hw/afs_frame_seq.sv ***
// converter frame sequencer: slot timing, filter start, reference chop,
// compute pass launch, remote sample path into compute RAM
// assumes i_clk_32k is synchronous to i_sys_clk and much slower than it
`timescale 1ns/10ps
`include "afs_consts.svh"
// Behaviour
// (R01) software holds slot count at zero while configuring, then sets it
// (R02) software programs only settings that match the compute program
// (R03) shunt mode: pair 0-1 differential, other pairs are remote interfaces
// (R04) transformer mode: all four pairs differential, all samples via the mux
// (R05) shunt frame of slot count six lasts thirteen 32k ticks
// (R06) remote samples taken in frame second half, written straight to RAM
// (R07) unused shunt slots are sequenced like any slot, only to stretch frame
// (R08) transformer frame of slot count seven lasts fifteen 32k ticks
// (R09) sequencer drives mux advance, filter start and reference swap by chop field
// (R10) each compute pass starts with a frame
// (R11) every mux state begins on a rising edge of the 32k clock
// (R12) slot length follows filter length and divider bit
// (R13) software should park slot count at zero while changing converter setup
// (R14) slot lasts (len+1)*(div+1) ticks, three times that when not fast
// (R15) frame lasts 3-2*fast ticks plus slot length times slot count
// (R16) four-bit select names input 0 to 10, at most eleven slots
// (R17) software fills unused slots with an otherwise unused valid handle
// (R18) slots run upward from zero, wrap each frame, idle when count is zero
module afs_frame_seq import afs_pkg::*; (
  // clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  // sequencer time base
  input  wire logic                       i_clk_32k,
  // register port
  input  wire logic [15:0]                i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [7:0]                 o_rdata,
  // multiplexer and filter
  output logic                            o_mux_advance,
  output logic      [3:0]                 o_mux_select,
  output logic                            o_fir_start,
  input  wire logic                       i_fir_valid,
  input  wire logic [`AFS_SAMPLE_W-1:0]   i_fir_data,
  // front end setup
  output logic                            o_ref_swap,
  output logic      [3:0]                 o_pair_differential,
  output logic      [2:0]                 o_pair_remote,
  // compute engine
  output logic                            o_ce_start,
  // remote sensors
  output logic                            o_rmt_sample,
  input  wire logic                       i_rmt_valid,
  output logic                            o_rmt_ready,
  input  wire logic [1:0]                 i_rmt_chan,
  input  wire logic [`AFS_SAMPLE_W-1:0]   i_rmt_data,
  // compute RAM write port
  output logic                            o_ram_wr,
  output logic      [3:0]                 o_ram_addr,
  output logic      [`AFS_SAMPLE_W-1:0]   o_ram_wdata,
  input  wire logic                       i_ram_ready
);
  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  function automatic logic [4:0] slot_dur(input logic [1:0] len, input logic div, input logic fast);
    logic [4:0] base;
    base = 5'({3'h0, len} + 5'h01) * 5'({4'h0, div} + 5'h01);
    return fast ? base : 5'(base * `AFS_SLOW_MULT);
  endfunction : slot_dur

  function automatic logic [8:0] frame_len(input logic [3:0] n, input logic [4:0] dur, input logic fast);
    logic [8:0] tail;
    tail = fast ? {5'h00, `AFS_TAIL_FAST} : {5'h00, `AFS_TAIL_SLOW};
    return 9'(tail + 9'({4'h0, dur} * {5'h00, n}));
  endfunction : frame_len

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [3:0]  sel_r [0:`AFS_NUM_SLOTS-1];
  logic [3:0]  slot_count_r;
  logic [7:0]  chop_r;
  logic [7:0]  fir_diff_r;
  logic [7:0]  adc_div_r;
  logic [7:0]  cfg_r;
  logic [7:0]  rdata_nxt;
  logic [2:0]  sel_pair;
  logic        sel_hit;

  afs_state_t  state_r;
  logic [3:0]  slot_idx_r;
  logic [4:0]  tcnt_r;
  logic [8:0]  ftick_r;
  logic        clk32_prev_r;
  logic        tick;
  logic [3:0]  eff_n;
  logic [4:0]  dur;
  logic [3:0]  tail_len;
  logic [8:0]  flen;
  logic        fast;
  logic        rmt_en;

  assign fast     = cfg_r[`AFS_CFG_FAST_BIT];
  assign rmt_en   = cfg_r[`AFS_CFG_RMT_BIT];
  assign eff_n    = (slot_count_r > `AFS_MAX_SLOT_CNT) ? `AFS_MAX_SLOT_CNT : slot_count_r; // [R16]
  assign dur      = slot_dur(fir_diff_r[`AFS_FIR_LSB+:2], adc_div_r[`AFS_DIV_BIT], fast); // [R12] [R14]
  assign tail_len = fast ? `AFS_TAIL_FAST : `AFS_TAIL_SLOW;
  assign flen     = frame_len(eff_n, dur, fast); // [R15] [R05] [R08]
  assign tick     = i_clk_32k & ~clk32_prev_r; // [R11]
  assign sel_pair = 3'(`AFS_OFF_SEL_LAST - i_addr);
  assign sel_hit  = (i_addr >= `AFS_OFF_SLOT_CNT + 16'h0001) && (i_addr <= `AFS_OFF_SEL_LAST);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < `AFS_NUM_SLOTS; k++) begin
        sel_r[k] <= `AFS_RST_NIB;
      end
      slot_count_r <= `AFS_RST_NIB;
      chop_r       <= `AFS_RST_BYTE;
      fir_diff_r   <= `AFS_RST_BYTE;
      adc_div_r    <= `AFS_RST_BYTE;
      cfg_r        <= `AFS_RST_BYTE;
    end else if (i_wr) begin
      if (i_addr == `AFS_OFF_SLOT_CNT) begin
        slot_count_r                <= i_wdata[7:4];
        sel_r[`AFS_NUM_SLOTS-1]     <= i_wdata[3:0];
      end
      if (sel_hit) begin
        sel_r[{sel_pair, 1'b0}]     <= i_wdata[3:0];
        sel_r[{sel_pair, 1'b1}]     <= i_wdata[7:4];
      end
      if (i_addr == `AFS_OFF_CHOP) begin
        chop_r <= i_wdata & `AFS_MASK_CHOP;
      end
      if (i_addr == `AFS_OFF_FIR_DIFF) begin
        fir_diff_r <= i_wdata & `AFS_MASK_FIR_DIFF;
      end
      if (i_addr == `AFS_OFF_ADC_DIV) begin
        adc_div_r <= i_wdata & `AFS_MASK_ADC_DIV;
      end
      if (i_addr == `AFS_OFF_SEQ_CFG) begin
        cfg_r <= i_wdata & `AFS_MASK_SEQ_CFG;
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic        fifo_valid;

  always_comb begin
    rdata_nxt = 8'h00;
    if (i_addr == `AFS_OFF_SLOT_CNT) begin
      rdata_nxt = {slot_count_r, sel_r[`AFS_NUM_SLOTS-1]};
    end else if (sel_hit) begin
      rdata_nxt = {sel_r[{sel_pair, 1'b1}], sel_r[{sel_pair, 1'b0}]};
    end else if (i_addr == `AFS_OFF_CHOP) begin
      rdata_nxt = chop_r;
    end else if (i_addr == `AFS_OFF_FIR_DIFF) begin
      rdata_nxt = fir_diff_r;
    end else if (i_addr == `AFS_OFF_ADC_DIV) begin
      rdata_nxt = adc_div_r;
    end else if (i_addr == `AFS_OFF_SEQ_CFG) begin
      rdata_nxt = cfg_r;
    end else if (i_addr == `AFS_OFF_STATUS) begin
      rdata_nxt = {~fifo_valid, o_ref_swap, state_r, slot_idx_r};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rdata_nxt : 8'h00;
    end
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  logic [3:0]  conv_handle_r;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      clk32_prev_r  <= 1'b0;
      state_r       <= AFS_ST_IDLE;
      slot_idx_r    <= 4'h0;
      tcnt_r        <= 5'h00;
      ftick_r       <= 9'h000;
      o_mux_advance <= 1'b0;
      o_mux_select  <= 4'h0;
      o_fir_start   <= 1'b0;
      o_ce_start    <= 1'b0;
      o_ref_swap    <= 1'b0;
      o_rmt_sample  <= 1'b0;
      conv_handle_r <= 4'h0;
    end else begin
      clk32_prev_r  <= i_clk_32k;
      o_mux_advance <= 1'b0;
      o_fir_start   <= 1'b0;
      o_ce_start    <= 1'b0;
      o_rmt_sample  <= 1'b0;
      if (tick) begin
        ftick_r <= ftick_r + 9'h001;
        tcnt_r  <= tcnt_r + 5'h01;
        if (rmt_en && state_r != AFS_ST_IDLE && (ftick_r + 9'h001) == {1'b0, flen[8:1]}) begin
          o_rmt_sample <= 1'b1; // [R06]
        end
        unique case (state_r)
          AFS_ST_IDLE: begin
            if (eff_n != 4'h0) begin
              state_r       <= AFS_ST_SLOT;
              slot_idx_r    <= 4'h0;
              tcnt_r        <= 5'h00;
              ftick_r       <= 9'h000;
              o_ce_start    <= 1'b1; // [R10]
              o_mux_advance <= 1'b1; // [R09]
              o_fir_start   <= 1'b1; // [R09]
              o_mux_select  <= sel_r[0];
              conv_handle_r <= sel_r[0];
              o_ref_swap    <= (chop_r[`AFS_CHOP_LSB+:2] == `AFS_CHOP_POS) ? 1'b0 :
                               (chop_r[`AFS_CHOP_LSB+:2] == `AFS_CHOP_NEG) ? 1'b1 : ~o_ref_swap; // [R09]
            end
          end
          AFS_ST_SLOT: begin
            if (eff_n == 4'h0) begin
              state_r <= AFS_ST_IDLE; // [R18]
            end else if (tcnt_r + 5'h01 >= dur) begin
              tcnt_r <= 5'h00;
              if (slot_idx_r + 4'h1 >= eff_n) begin
                state_r <= AFS_ST_TAIL; // [R15]
              end else begin
                // dummy slots get the same timing as live ones
                slot_idx_r    <= slot_idx_r + 4'h1; // [R18] [R07]
                o_mux_advance <= 1'b1;
                o_fir_start   <= 1'b1;
                o_mux_select  <= sel_r[slot_idx_r + 4'h1];
                conv_handle_r <= sel_r[slot_idx_r + 4'h1];
              end
            end
          end
          AFS_ST_TAIL: begin
            if (eff_n == 4'h0) begin
              state_r <= AFS_ST_IDLE; // [R18]
            end else if (tcnt_r + 5'h01 >= {1'b0, tail_len}) begin
              state_r       <= AFS_ST_SLOT; // [R18]
              slot_idx_r    <= 4'h0;
              tcnt_r        <= 5'h00;
              ftick_r       <= 9'h000;
              o_ce_start    <= 1'b1; // [R10]
              o_mux_advance <= 1'b1;
              o_fir_start   <= 1'b1;
              o_mux_select  <= sel_r[0];
              conv_handle_r <= sel_r[0];
              o_ref_swap    <= (chop_r[`AFS_CHOP_LSB+:2] == `AFS_CHOP_POS) ? 1'b0 :
                               (chop_r[`AFS_CHOP_LSB+:2] == `AFS_CHOP_NEG) ? 1'b1 : ~o_ref_swap; // [R09]
            end
          end
          default: state_r <= AFS_ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // front end mode
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pair_differential <= 4'h0;
      o_pair_remote       <= 3'h0;
    end else begin
      o_pair_differential <= rmt_en ? `AFS_SHUNT_DIFF : `AFS_CT_DIFF; // [R03] [R04]
      o_pair_remote       <= {3{rmt_en}}; // [R03] [R04]
    end
  end

  // ----------------------------------------
  // sample path into compute RAM
  // ----------------------------------------
  logic [`AFS_RMT_WORD_W-1:0] fifo_data;
  logic [3:0]                 fifo_count;
  logic                       fifo_push;
  logic                       fifo_pop;
  logic                       ram_free;
  logic                       fir_hold_v_r;
  logic [3:0]                 fir_hold_a_r;
  logic [`AFS_SAMPLE_W-1:0]   fir_hold_d_r;
  logic [3:0]                 level_nxt;

  // remote samples skip the mux; dropped when remote sensing is off
  assign fifo_push = rmt_en & i_rmt_valid & o_rmt_ready; // [R06] [R04]
  assign ram_free  = ~o_ram_wr | i_ram_ready;
  assign fifo_pop  = ram_free & ~fir_hold_v_r & fifo_valid;
  assign level_nxt = fifo_count + {3'h0, fifo_push} - {3'h0, fifo_pop};

  afs_fifo #(
    .WIDTH (`AFS_RMT_WORD_W),
    .DEPTH (`AFS_FIFO_DEPTH)
  ) u_rmt_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (fifo_push),
    .o_in_ready  (),
    .i_in_data   ({i_rmt_chan, i_rmt_data}),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data),
    .o_count     (fifo_count)
  );

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rmt_ready  <= 1'b0;
      fir_hold_v_r <= 1'b0;
      fir_hold_a_r <= 4'h0;
      fir_hold_d_r <= '0;
      o_ram_wr     <= 1'b0;
      o_ram_addr   <= 4'h0;
      o_ram_wdata  <= '0;
    end else begin
      o_rmt_ready <= ~rmt_en | (level_nxt < 4'(`AFS_FIFO_DEPTH));
      if (ram_free) begin
        o_ram_wr <= fir_hold_v_r | fifo_valid;
        if (fir_hold_v_r) begin
          o_ram_addr  <= fir_hold_a_r;
          o_ram_wdata <= fir_hold_d_r;
        end else if (fifo_valid) begin
          o_ram_addr  <= 4'(`AFS_RMT_ADDR_BASE + {2'h0, fifo_data[`AFS_RMT_WORD_W-1 -: 2]}); // [R06]
          o_ram_wdata <= fifo_data[`AFS_SAMPLE_W-1:0];
        end
      end
      // a new filter result wins over the slot being emptied
      if (i_fir_valid) begin
        fir_hold_v_r <= 1'b1;
        fir_hold_a_r <= conv_handle_r;
        fir_hold_d_r <= i_fir_data;
      end else if (ram_free) begin
        fir_hold_v_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [8:0] frame_gap_r;
  logic [4:0] slot_gap_r;
  logic       meas_ok_r;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_gap_r <= 9'h000;
      slot_gap_r  <= 5'h00;
      meas_ok_r   <= 1'b0;
    end else begin
      frame_gap_r <= o_ce_start ? {8'h00, tick} : frame_gap_r + {8'h00, tick};
      slot_gap_r  <= o_fir_start ? {4'h0, tick} : slot_gap_r + {4'h0, tick};
      meas_ok_r   <= i_wr ? 1'b0 : (o_ce_start ? 1'b1 : meas_ok_r);
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_idle_quiet;
    (state_r == AFS_ST_IDLE && slot_count_r == 4'h0) |=> !o_fir_start && !o_ce_start;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("conversion started with zero slots"); // [R18]

  property p_frame_shunt;
    (o_ce_start && meas_ok_r && fast && eff_n == 4'h6 && dur == 5'h02) |-> frame_gap_r == 9'd13;
  endproperty
  a_frame_shunt: assert property (p_frame_shunt) else $error("shunt frame not 13 ticks"); // [R05]

  property p_frame_ct;
    (o_ce_start && meas_ok_r && fast && eff_n == 4'h7 && dur == 5'h02) |-> frame_gap_r == 9'd15;
  endproperty
  a_frame_ct: assert property (p_frame_ct) else $error("transformer frame not 15 ticks"); // [R08]

  property p_frame_len;
    (o_ce_start && meas_ok_r) |-> frame_gap_r == flen;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length mismatch"); // [R15]

  property p_slot_len;
    (o_fir_start && !o_ce_start && meas_ok_r) |-> slot_gap_r == dur;
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length mismatch"); // [R14]

  property p_slot_slow;
    (o_fir_start && !o_ce_start && meas_ok_r && !fast) |-> slot_gap_r >= 5'h03;
  endproperty
  a_slot_slow: assert property (p_slot_slow) else $error("slow slot shorter than three ticks"); // [R12]

  property p_ce_lock;
    o_ce_start |-> o_fir_start && o_mux_advance && slot_idx_r == 4'h0 && o_mux_select == $past(sel_r[0]);
  endproperty
  a_ce_lock: assert property (p_ce_lock) else $error("pass not aligned to frame start"); // [R10]

  property p_on_edge;
    (o_mux_advance || o_ce_start) |-> $past(tick);
  endproperty
  a_on_edge: assert property (p_on_edge) else $error("mux state not on 32k edge"); // [R11]

  property p_chop_fixed;
    (o_ce_start && chop_r[`AFS_CHOP_LSB+:2] == `AFS_CHOP_NEG && $stable(chop_r)) |-> o_ref_swap;
  endproperty
  a_chop_fixed: assert property (p_chop_fixed) else $error("reference swap not held"); // [R09]

  property p_remote_half;
    o_rmt_sample |-> rmt_en && ftick_r == {1'b0, flen[8:1]} ##1 !o_rmt_sample;
  endproperty
  a_remote_half: assert property (p_remote_half) else $error("remote sample outside second half"); // [R06]

  property p_mode_map;
    $past(rmt_en) |-> o_pair_differential == `AFS_SHUNT_DIFF && o_pair_remote == 3'h7;
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("shunt front end map wrong"); // [R03]

  property p_ct_map;
    (!$past(rmt_en) && !$past(i_rst)) |-> o_pair_differential == `AFS_CT_DIFF && o_pair_remote == 3'h0;
  endproperty
  a_ct_map: assert property (p_ct_map) else $error("transformer front end map wrong"); // [R04]

  c_frame_run: cover property (o_ce_start ##[1:300] o_ce_start);
  c_remote_write: cover property (o_rmt_sample ##[1:1000] (o_ram_wr && o_ram_addr >= `AFS_RMT_ADDR_BASE));
  c_fifo_full: cover property (fifo_count == 4'(`AFS_FIFO_DEPTH));
  c_stop: cover property (state_r == AFS_ST_SLOT ##1 state_r == AFS_ST_IDLE);
endmodule : afs_frame_seq

// *** hw/afs_pkg.sv ***
// types shared by the frame sequencer files
// assumes afs_consts.svh is on the include path
package afs_pkg;
  typedef enum logic [1:0] {
    AFS_ST_IDLE = 2'b00,
    AFS_ST_SLOT = 2'b01,
    AFS_ST_TAIL = 2'b10
  } afs_state_t;
endpackage : afs_pkg

// *** verif/afs_sensor_model.sv ***
// sensor side model: filter results and three remote sensor samples a frame
// assumes start and sample pulses come from the sequencer on i_sys_clk
`timescale 1ns/10ps
module afs_sensor_model (
  // clock
  input  wire logic        i_sys_clk,
  // sequencer pulses
  input  wire logic        i_fir_start,
  input  wire logic        i_rmt_sample,
  input  wire logic        i_rmt_ready,
  // filter result and remote stream
  output logic             o_fir_valid = 1'b0,
  output logic [23:0]      o_fir_data  = 24'h000000,
  output logic             o_rmt_valid = 1'b0,
  output logic [1:0]       o_rmt_chan  = 2'h0,
  output logic [23:0]      o_rmt_data  = 24'h000000
);
  logic [2:0] dly_r = 3'h0;
  // filter answers four cycles after its start
  always @(posedge i_sys_clk) begin
    dly_r       <= {dly_r[1:0], i_fir_start};
    o_fir_valid <= dly_r[2];
    o_fir_data  <= ~o_fir_data;
  end
  // one sample per remote pair, held until taken, bypassing the mux
  // low data bits carry the channel so the bench can check the RAM slot
  always @(posedge i_sys_clk) begin
    if (i_rmt_sample) o_rmt_valid <= 1'b1;
    else if (o_rmt_valid && i_rmt_ready) begin
      o_rmt_valid <= (o_rmt_chan != 2'h2);
      o_rmt_chan  <= (o_rmt_chan == 2'h2) ? 2'h0 : o_rmt_chan + 2'h1;
      o_rmt_data  <= {22'h0, (o_rmt_chan == 2'h2) ? 2'h0 : o_rmt_chan + 2'h1};
    end
  end
endmodule : afs_sensor_model

// *** verif/test_afs_frame_seq.sv ***
// self-checking bench: registers, frame timing, slot order, remote path
// assumes a scaled time base of one tick every 16 system cycles
`timescale 1ns/10ps
`include "afs_consts.svh"
module test_afs_frame_seq import afs_pkg::*; ;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_clk_32k = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_ram_ready = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0]  i_wdata = 8'h00, o_rdata;
  logic        o_mux_advance, o_fir_start, i_fir_valid, o_ref_swap, o_ce_start, o_rmt_sample;
  logic        i_rmt_valid, o_rmt_ready, o_ram_wr;
  logic [3:0]  o_mux_select, o_pair_differential, o_ram_addr;
  logic [2:0]  o_pair_remote;
  logic [1:0]  i_rmt_chan;
  logic [23:0] i_fir_data, i_rmt_data, o_ram_wdata;
  logic [3:0]  seen [0:10];
  logic [15:0] offs [3] = '{`AFS_OFF_CHOP, `AFS_OFF_FIR_DIFF, `AFS_OFF_ADC_DIV};
  logic [7:0]  msk [3] = '{8'hEC, 8'h36, 8'h20};
  logic [3:0]  sel_exp [7] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'h3};
  int failures, checks_done, cyc, last_ce, gap, nce, idx, last_n, nrmt, last_rmt, nadv, n_hold;

  afs_frame_seq i_afs_frame_seq (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_32k(i_clk_32k),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_mux_advance(o_mux_advance), .o_mux_select(o_mux_select), .o_fir_start(o_fir_start),
    .i_fir_valid(i_fir_valid), .i_fir_data(i_fir_data), .o_ref_swap(o_ref_swap),
    .o_pair_differential(o_pair_differential), .o_pair_remote(o_pair_remote), .o_ce_start(o_ce_start),
    .o_rmt_sample(o_rmt_sample), .i_rmt_valid(i_rmt_valid), .o_rmt_ready(o_rmt_ready),
    .i_rmt_chan(i_rmt_chan), .i_rmt_data(i_rmt_data), .o_ram_wr(o_ram_wr), .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata), .i_ram_ready(i_ram_ready));
  afs_sensor_model i_afs_sensor_model (.i_sys_clk(i_sys_clk), .i_fir_start(o_fir_start),
    .i_rmt_sample(o_rmt_sample), .i_rmt_ready(o_rmt_ready), .o_fir_valid(i_fir_valid),
    .o_fir_data(i_fir_data), .o_rmt_valid(i_rmt_valid), .o_rmt_chan(i_rmt_chan), .o_rmt_data(i_rmt_data));

  always #25 i_sys_clk = ~i_sys_clk;
  always begin
    repeat (8) @(posedge i_sys_clk);
    i_clk_32k <= ~i_clk_32k;
  end
  // ----------------------------------------
  // frame monitor, ram stalls half the time
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_ram_wr && i_ram_ready && o_ram_addr >= 4'hB) begin
      nrmt++;
      chk("ram_addr", {12'h000, `AFS_RMT_ADDR_BASE + {2'h0, o_ram_wdata[1:0]}}, {12'h000, o_ram_addr});
    end
    if (o_ce_start) begin
      gap = cyc - last_ce;
      last_ce = cyc;
      last_n = idx;
      last_rmt = nrmt;
      idx = 0;
      nrmt = 0;
      nce++;
    end
    if (o_mux_advance) begin
      nadv++;
      if (idx < 11) seen[idx] = o_mux_select;
      idx++;
    end
    i_ram_ready <= cyc[1];
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, o_rdata});
  endtask : rd
  task automatic setup(input logic [7:0] cfg, fir, div, cnt, chp);
    wr(`AFS_OFF_SLOT_CNT, 8'h00);
    wr(`AFS_OFF_SEQ_CFG, cfg);
    wr(`AFS_OFF_FIR_DIFF, fir);
    wr(`AFS_OFF_ADC_DIV, div);
    wr(`AFS_OFF_CHOP, chp);
    wr(`AFS_OFF_SLOT_CNT, cnt);
  endtask : setup
  task automatic frame(input int ticks, input logic [3:0] n, input logic [3:0] rmt);
    int n0;
    n0 = nce;
    repeat (3000) if (nce < n0 + 3) @(posedge i_sys_clk);
    #1 chk("frame", ticks * 16, gap[15:0]);
    chk("slots", {12'h000, n}, {12'h000, last_n[3:0]});
    chk("remote", {12'h000, rmt}, {12'h000, last_rmt[3:0]});
  endtask : frame
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (offs[k]) begin
      rd(offs[k], 8'h00);
      wr(offs[k], 8'hFF);
      rd(offs[k], msk[k]);
    end
    rd(16'h2107, 8'h00);
    setup(8'h03, 8'h02, 8'h00, 8'h60, 8'h08);
    wr(16'h2105, 8'h10);
    wr(16'h2104, 8'h82);
    wr(16'h2103, 8'hA9);
    wr(16'h2102, 8'h03);
    frame(13, 4'h6, 4'h3);
    chk("differential", 16'h0001, {12'h000, o_pair_differential});
    chk("remote_pairs", 16'h0007, {13'h0000, o_pair_remote});
    for (int k = 0; k < 6; k++) chk("select", {12'h000, sel_exp[k]}, {12'h000, seen[k]});
    setup(8'h01, 8'h32, 8'h00, 8'h70, 8'h08);
    frame(15, 4'h7, 4'h0);
    chk("select6", {12'h000, sel_exp[6]}, {12'h000, seen[6]});
    chk("differential", 16'h000F, {12'h000, o_pair_differential});
    chk("ref_swap", 16'h0001, {15'h0000, o_ref_swap});
    setup(8'h01, 8'h06, 8'h20, 8'h20, 8'h04);
    frame(17, 4'h2, 4'h0);
    chk("ref_swap_pos", 16'h0000, {15'h0000, o_ref_swap});
    setup(8'h00, 8'h00, 8'h00, 8'h10, 8'h0C);
    frame(6, 4'h1, 4'h0);
    setup(8'h00, 8'h00, 8'h00, 8'h20, 8'h08);
    frame(9, 4'h2, 4'h0);
    setup(8'h01, 8'h00, 8'h00, 8'hF0, 8'h08);
    frame(12, 4'hB, 4'h0);
    wr(`AFS_OFF_SLOT_CNT, 8'h00);
    repeat (40) @(posedge i_sys_clk);
    n_hold = nadv;
    repeat (400) @(posedge i_sys_clk);
    chk("idle", n_hold[15:0], nadv[15:0]);
    print_verdict;
  end
endmodule : test_afs_frame_seq
